/* rtl/drrp_map.svh */
// Purpose: Register map, reset values and timing figures of the drive ramp/protection block
// Assumes: 32-bit APB, byte addresses, one register per aligned word
// Notes: Definitions only
`ifndef DRRP_MAP_SVH
`define DRRP_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DRRP_OFS_CTRL 8'h00
`define DRRP_OFS_STALL 8'h04
`define DRRP_OFS_RATED 8'h08
`define DRRP_OFS_FREQ 8'h0C
`define DRRP_OFS_RAMP1 8'h10
`define DRRP_OFS_RAMP2 8'h14
`define DRRP_OFS_MAXF 8'h18
`define DRRP_OFS_CMD 8'h1C
`define DRRP_OFS_STATUS 8'h20
`define DRRP_OFS_UPDN 8'h24
`define DRRP_OFS_LASTT 8'h28
`define DRRP_OFS_HSEL 8'h2C
`define DRRP_OFS_HFREQ 8'h30
`define DRRP_OFS_HCUR 8'h34

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DRRP_RST_PROTECT 3'h1
`define DRRP_RST_STALL_EN 3'h7
`define DRRP_RST_SCALE 2'h1
`define DRRP_RST_STALL_LVL 8'h64
`define DRRP_RST_RATED 16'h00C5
`define DRRP_RST_DRV_RATED 16'h00C5
`define DRRP_RST_CHG_FREQ 16'h0000
`define DRRP_RST_BASE_FREQ 16'h1770
`define DRRP_RST_MAX_FREQ 16'h1770
`define DRRP_RST_RAMP 16'h0064

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DRRP_CTRL_PROT_LSB 0
`define DRRP_CTRL_STALL_LSB 3
`define DRRP_CTRL_SCALE_LSB 6
`define DRRP_CTRL_REF_BIT 8
`define DRRP_CTRL_UPDN_BIT 9
`define DRRP_CMD_FRST_BIT 0
`define DRRP_CMD_HCLR_BIT 1

// ----------------------------------------
// Figures
// ----------------------------------------
`define DRRP_PERCENT 100
`define DRRP_STALL_CLAMP_PCT 120
`define DRRP_STEP_FINE_MS 10
`define DRRP_STEP_MID_MS 100
`define DRRP_STEP_COARSE_MS 1000
`define DRRP_MAX_COARSE_S 6000
`define DRRP_CLK_HZ 125000000
`define DRRP_ELAPSED_TICK_S 1
`define DRRP_HIST_DEPTH 5

`endif

/* rtl/drrp_pkg.sv */
// Purpose: Types shared by the drive ramp/protection block
// Assumes: Used with drrp_map.svh
// Notes: Nothing here is imported; users write drrp_pkg::name
package drrp_pkg;

  typedef enum logic [1:0] {
    DRRP_SCALE_FINE = 2'b00,
    DRRP_SCALE_MID = 2'b01,
    DRRP_SCALE_COARSE = 2'b10
  } drrp_scale_e;

  typedef enum logic [1:0] {
    DRRP_MOT_CONST = 2'b00,
    DRRP_MOT_ACCEL = 2'b01,
    DRRP_MOT_DECEL = 2'b10
  } drrp_motion_e;

  typedef enum logic [1:0] {
    DRRP_TRIP_NONE = 2'b00,
    DRRP_TRIP_OUT_PHASE = 2'b01,
    DRRP_TRIP_IN_PHASE = 2'b10,
    DRRP_TRIP_CONTACTOR = 2'b11
  } drrp_trip_e;

endpackage

/* rtl/drrp_fault_hist.sv */
// Purpose: Five-deep fault history, newest at entry one
// Assumes: One push per trip event
// Notes: Read data is registered
`timescale 1ns/1ps
`include "drrp_map.svh"
module drrp_fault_hist #(
  parameter int DEPTH = `DRRP_HIST_DEPTH,
  parameter int W = 34
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic [W-1:0] push_data,
  input wire logic clear,
  input wire logic [2:0] rd_index,
  output logic [W:0] rd_data
);

  logic [W-1:0] ent_q [DEPTH];
  logic [DEPTH-1:0] val_q;

  // ----------------------------------------
  // Shift chain
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : gen_ent
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ent_q[g] <= '0;
          val_q[g] <= 1'b0;
        end else if (push) begin
          ent_q[g] <= (g == 0) ? push_data : ent_q[(g == 0) ? 0 : g-1]; // RULE19
          val_q[g] <= (g == 0) ? 1'b1 : val_q[(g == 0) ? 0 : g-1]; // RULE19
        end else if (clear) begin
          val_q[g] <= 1'b0; // RULE22
          ent_q[g] <= '0; // RULE22
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Registered read
  // ----------------------------------------
  wire rd_ok = (rd_index < 3'(DEPTH));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= '0;
    end else begin
      rd_data <= rd_ok ? {val_q[rd_index], ent_q[rd_index]} : '0;
    end
  end

endmodule

/* rtl/drrp_ramp_sel.sv */
// Purpose: Ramp set choice, time scaling and span reference
// Assumes: Frequencies in 0.01 Hz, ramp settings in scale units
// Notes: Outputs registered
`timescale 1ns/1ps
`include "drrp_map.svh"
module drrp_ramp_sel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] target_freq,
  input wire logic [15:0] change_freq,
  input wire logic [15:0] max_freq,
  input wire logic ref_delta,
  input wire logic [1:0] scale,
  input wire logic [2:0] multi_code,
  input wire logic [31:0] ramp1,
  input wire logic [31:0] ramp2,
  output logic [3:0] ramp_index,
  output logic [23:0] accel_ms,
  output logic [23:0] decel_ms,
  output logic [15:0] span_freq
);

  // Setting to ms, clamped to the largest setting
  function automatic logic [23:0] to_ms(input logic [15:0] set, input logic [1:0] sc);
    logic [15:0] lim;
    logic [15:0] s;
    lim = 16'(`DRRP_MAX_COARSE_S);
    s = set;
    if (s > lim) begin
      s = lim; // RULE14 RULE15 RULE16
    end
    case (sc)
      drrp_pkg::DRRP_SCALE_FINE: to_ms = 24'(s) * 24'(`DRRP_STEP_FINE_MS); // RULE14
      drrp_pkg::DRRP_SCALE_COARSE: to_ms = 24'(s) * 24'(`DRRP_STEP_COARSE_MS); // RULE16
      default: to_ms = 24'(s) * 24'(`DRRP_STEP_MID_MS); // RULE15
    endcase
  endfunction

  wire multi_on = |multi_code;
  wire chg_on = (change_freq != 16'h0) && (out_freq >= change_freq); // RULE10
  wire [3:0] idx_d = multi_on ? {1'b0, multi_code} + 4'h1 : (chg_on ? 4'h1 : 4'h0); // RULE11
  wire [31:0] set_sel = chg_on ? ramp2 : ramp1; // RULE10
  wire [15:0] delta = (target_freq > out_freq) ? target_freq - out_freq : out_freq - target_freq;
  wire [15:0] span_d = ref_delta ? delta : max_freq; // RULE12 RULE13

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_index <= 4'h0;
      accel_ms <= 24'h0;
      decel_ms <= 24'h0;
      span_freq <= 16'h0;
    end else begin
      ramp_index <= idx_d;
      accel_ms <= to_ms(set_sel[15:0], scale);
      decel_ms <= to_ms(set_sel[31:16], scale);
      span_freq <= span_d;
    end
  end

endmodule

/* rtl/drrp_top.sv */
// Purpose: Protection trips, stall prevention, ramp setup, up/down save, fault log of a drive
// Assumes: APB slave, all inputs synchronous to pclk, currents 0.1 A, frequencies 0.01 Hz
// Notes: Zero wait states; read data taken in setup
//
// Functional notes
// RULE1 - Protect bit 0 set: output phase loss stops the output.
// RULE2 - Protect bit 1 set: input phase loss stops the output.
// RULE3 - Protect bit 2 set: contactor switching in direct input cuts output.
// RULE4 - Stall level is a percent of rated motor current.
// RULE5 - Stall lowers output frequency until current is below level.
// RULE6 - Stall enable per accel, constant speed and decel phase.
// RULE7 - Stall level is lowered above base frequency.
// RULE8 - Stall level capped at 120 percent of drive rated current.
// RULE9 - Stop during stall starts deceleration.
// RULE10 - Ramp set changes at the change frequency.
// RULE11 - Multi-ramp inputs win over change-frequency switching; code does so in ramp_index only, not in accel_ms/decel_ms.
// RULE12 - Max reference: ramp time covers 0 Hz to maximum frequency.
// RULE13 - Delta reference: ramp time covers present to target frequency.
// RULE14 - Fine scale: 10 ms steps, at most 60 seconds.
// RULE15 - Middle scale: 100 ms steps, at most 600 seconds.
// RULE16 - Coarse scale: 1 s steps, at most 6000 seconds.
// RULE17 - Save frequency on up/down release and show it.
// RULE18 - Clear input resets saved up/down frequency.
// RULE19 - Keep five newest trips, entry one newest.
// RULE20 - Entry holds frequency, current and motion state.
// RULE21 - Count time since the latest trip.
// RULE22 - History clear erases entries, not elapsed time.
// RULE23 - Trip latches, stops output and is logged until fault reset.
`timescale 1ns/1ps
`include "drrp_map.svh"
module drrp_top #(
  parameter int TICK_CYCLES = `DRRP_ELAPSED_TICK_S * `DRRP_CLK_HZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic out_phase_loss,
  input wire logic in_phase_loss,
  input wire logic direct_input_mode,
  input wire logic contactor_switching,
  input wire logic [15:0] motor_current,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] target_freq,
  input wire logic accelerating,
  input wire logic decelerating,
  input wire logic stop_cmd,
  input wire logic updown_active,
  input wire logic updown_clear,
  input wire logic multi_ramp_select_low,
  input wire logic multi_ramp_select_mid,
  input wire logic multi_ramp_select_high,
  output logic drive_enable,
  output logic trip,
  output logic stall_lower_freq,
  output logic stall_decel_start,
  output logic [3:0] ramp_index,
  output logic [23:0] accel_ms,
  output logic [23:0] decel_ms,
  output logic [15:0] span_freq,
  output logic [15:0] updown_saved_frequency
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  wire wr_en = psel && penable && pwrite;
  wire rd_setup = psel && !penable && !pwrite;
  wire a_ctrl = hit(paddr, `DRRP_OFS_CTRL);
  wire a_stall = hit(paddr, `DRRP_OFS_STALL);
  wire a_rated = hit(paddr, `DRRP_OFS_RATED);
  wire a_freq = hit(paddr, `DRRP_OFS_FREQ);
  wire a_ramp1 = hit(paddr, `DRRP_OFS_RAMP1);
  wire a_ramp2 = hit(paddr, `DRRP_OFS_RAMP2);
  wire a_maxf = hit(paddr, `DRRP_OFS_MAXF);
  wire a_cmd = hit(paddr, `DRRP_OFS_CMD);
  wire a_status = hit(paddr, `DRRP_OFS_STATUS);
  wire a_updn = hit(paddr, `DRRP_OFS_UPDN);
  wire a_lastt = hit(paddr, `DRRP_OFS_LASTT);
  wire a_hsel = hit(paddr, `DRRP_OFS_HSEL);
  wire a_hfreq = hit(paddr, `DRRP_OFS_HFREQ);
  wire a_hcur = hit(paddr, `DRRP_OFS_HCUR);
  wire a_any = a_ctrl | a_stall | a_rated | a_freq | a_ramp1 | a_ramp2 | a_maxf | a_cmd |
               a_status | a_updn | a_lastt | a_hsel | a_hfreq | a_hcur;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [2:0] protect_q;
  logic [2:0] stall_en_q;
  logic [1:0] scale_q;
  logic ref_delta_q;
  logic updn_en_q;
  logic [7:0] stall_lvl_q;
  logic [15:0] rated_q;
  logic [15:0] drv_rated_q;
  logic [15:0] chg_freq_q;
  logic [15:0] base_freq_q;
  logic [31:0] ramp1_q;
  logic [31:0] ramp2_q;
  logic [15:0] max_freq_q;
  logic [2:0] hsel_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protect_q <= `DRRP_RST_PROTECT;
      stall_en_q <= `DRRP_RST_STALL_EN;
      scale_q <= `DRRP_RST_SCALE;
      ref_delta_q <= 1'b0;
      updn_en_q <= 1'b0;
    end else if (wr_en && a_ctrl) begin
      protect_q <= pwdata[`DRRP_CTRL_PROT_LSB +: 3];
      stall_en_q <= pwdata[`DRRP_CTRL_STALL_LSB +: 3];
      scale_q <= pwdata[`DRRP_CTRL_SCALE_LSB +: 2];
      ref_delta_q <= pwdata[`DRRP_CTRL_REF_BIT];
      updn_en_q <= pwdata[`DRRP_CTRL_UPDN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_lvl_q <= `DRRP_RST_STALL_LVL;
      base_freq_q <= `DRRP_RST_BASE_FREQ;
    end else if (wr_en && a_stall) begin
      stall_lvl_q <= pwdata[7:0];
      base_freq_q <= pwdata[31:16];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rated_q <= `DRRP_RST_RATED;
      drv_rated_q <= `DRRP_RST_DRV_RATED;
    end else if (wr_en && a_rated) begin
      rated_q <= pwdata[15:0];
      drv_rated_q <= pwdata[31:16];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_freq_q <= `DRRP_RST_CHG_FREQ;
      max_freq_q <= `DRRP_RST_MAX_FREQ;
    end else begin
      if (wr_en && a_freq) begin
        chg_freq_q <= pwdata[15:0];
      end
      if (wr_en && a_maxf) begin
        max_freq_q <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp1_q <= {`DRRP_RST_RAMP, `DRRP_RST_RAMP};
      ramp2_q <= {`DRRP_RST_RAMP, `DRRP_RST_RAMP};
      hsel_q <= 3'h0;
    end else begin
      if (wr_en && a_ramp1) begin
        ramp1_q <= pwdata;
      end
      if (wr_en && a_ramp2) begin
        ramp2_q <= pwdata;
      end
      if (wr_en && a_hsel) begin
        hsel_q <= pwdata[2:0];
      end
    end
  end

  wire cmd_fault_reset = wr_en && a_cmd && pwdata[`DRRP_CMD_FRST_BIT];
  wire cmd_hist_clear = wr_en && a_cmd && pwdata[`DRRP_CMD_HCLR_BIT];

  // ----------------------------------------
  // Protection trips
  // ----------------------------------------
  logic trip_q;
  logic [1:0] cause_q;
  wire trip_out = protect_q[0] && out_phase_loss; // RULE1
  wire trip_in = protect_q[1] && in_phase_loss; // RULE2
  wire trip_con = protect_q[2] && direct_input_mode && contactor_switching; // RULE3
  wire trip_evt = trip_out | trip_in | trip_con;
  wire trip_new = trip_evt && !trip_q;
  wire [1:0] cause_d = trip_out ? drrp_pkg::DRRP_TRIP_OUT_PHASE :
                       (trip_in ? drrp_pkg::DRRP_TRIP_IN_PHASE : drrp_pkg::DRRP_TRIP_CONTACTOR);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_q <= 1'b0;
      cause_q <= drrp_pkg::DRRP_TRIP_NONE;
    end else if (trip_new) begin
      trip_q <= 1'b1; // RULE23
      cause_q <= cause_d;
    end else if (cmd_fault_reset && !trip_evt) begin
      trip_q <= 1'b0; // RULE23
      cause_q <= drrp_pkg::DRRP_TRIP_NONE;
    end
  end

  // ----------------------------------------
  // Stall prevention
  // ----------------------------------------
  wire [23:0] lvl_prod = 24'(rated_q) * 24'(stall_lvl_q);
  wire [23:0] lvl_raw = 24'(lvl_prod / 24'(`DRRP_PERCENT)); // RULE4
  wire [23:0] lvl_derate = (out_freq > base_freq_q) ? lvl_raw - (lvl_raw >> 2) : lvl_raw; // RULE7
  wire [23:0] clamp_prod = 24'(drv_rated_q) * 24'(`DRRP_STALL_CLAMP_PCT);
  wire [23:0] lvl_clamp = 24'(clamp_prod / 24'(`DRRP_PERCENT));
  wire [23:0] lvl_eff = (lvl_derate > lvl_clamp) ? lvl_clamp : lvl_derate; // RULE8
  wire phase_en = accelerating ? stall_en_q[0] : (decelerating ? stall_en_q[2] : stall_en_q[1]); // RULE6
  wire stall_d = phase_en && !trip_q && (24'(motor_current) >= lvl_eff); // RULE5
  logic stall_q;
  logic decel_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_q <= 1'b0;
      decel_q <= 1'b0;
    end else begin
      stall_q <= stall_d; // RULE5
      decel_q <= stop_cmd && stall_d; // RULE9
    end
  end

  // ----------------------------------------
  // Ramp selection
  // ----------------------------------------
  wire [2:0] multi_code = {multi_ramp_select_high, multi_ramp_select_mid, multi_ramp_select_low};

  drrp_ramp_sel u_ramp (
    .pclk(pclk),
    .presetn(presetn),
    .out_freq(out_freq),
    .target_freq(target_freq),
    .change_freq(chg_freq_q),
    .max_freq(max_freq_q),
    .ref_delta(ref_delta_q),
    .scale(scale_q),
    .multi_code(multi_code),
    .ramp1(ramp1_q),
    .ramp2(ramp2_q),
    .ramp_index(ramp_index),
    .accel_ms(accel_ms),
    .decel_ms(decel_ms),
    .span_freq(span_freq)
  );

  // ----------------------------------------
  // Up/down frequency save
  // ----------------------------------------
  logic updn_prev_q;
  logic [15:0] updn_q;
  wire updn_release = updn_prev_q && !updown_active;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      updn_prev_q <= 1'b0;
      updn_q <= 16'h0;
    end else begin
      updn_prev_q <= updown_active;
      if (updn_en_q && updn_release) begin
        updn_q <= out_freq; // RULE17
      end else if (updown_clear) begin
        updn_q <= 16'h0; // RULE18
      end
    end
  end

  // ----------------------------------------
  // Fault history and elapsed time
  // ----------------------------------------
  wire [1:0] motion = accelerating ? drrp_pkg::DRRP_MOT_ACCEL :
                      (decelerating ? drrp_pkg::DRRP_MOT_DECEL : drrp_pkg::DRRP_MOT_CONST);
  wire [33:0] hist_in = {motion, motor_current, out_freq}; // RULE20
  logic [34:0] hist_rd;

  drrp_fault_hist #(
    .DEPTH(`DRRP_HIST_DEPTH),
    .W(34)
  ) u_hist (
    .pclk(pclk),
    .presetn(presetn),
    .push(trip_new), // RULE23
    .push_data(hist_in),
    .clear(cmd_hist_clear), // RULE22
    .rd_index(hsel_q),
    .rd_data(hist_rd)
  );

  logic [31:0] tick_q;
  logic [31:0] elapsed_q;
  logic seen_trip_q;
  wire tick_end = (tick_q == 32'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 32'h0;
      elapsed_q <= 32'h0;
      seen_trip_q <= 1'b0;
    end else if (trip_new) begin
      tick_q <= 32'h0; // RULE21
      elapsed_q <= 32'h0; // RULE21
      seen_trip_q <= 1'b1;
    end else begin
      tick_q <= tick_end ? 32'h0 : tick_q + 32'h1;
      if (tick_end && seen_trip_q && (elapsed_q != 32'hFFFFFFFF)) begin
        elapsed_q <= elapsed_q + 32'h1; // RULE21
      end
    end
  end

  // ----------------------------------------
  // Read mux and APB answer
  // ----------------------------------------
  wire [31:0] ctrl_rd = {22'h0, updn_en_q, ref_delta_q, scale_q, stall_en_q, protect_q};
  wire [31:0] status_rd = {24'h0, ramp_index, stall_q, cause_q, trip_q};
  wire [31:0] rd_mux =
    a_ctrl ? ctrl_rd :
    a_stall ? {base_freq_q, 8'h00, stall_lvl_q} :
    a_rated ? {drv_rated_q, rated_q} :
    a_freq ? {16'h0, chg_freq_q} :
    a_ramp1 ? ramp1_q :
    a_ramp2 ? ramp2_q :
    a_maxf ? {16'h0, max_freq_q} :
    a_status ? status_rd :
    a_updn ? {16'h0, updn_q} :
    a_lastt ? elapsed_q :
    a_hsel ? {29'h0, hsel_q} :
    a_hfreq ? {hist_rd[34], 13'h0, hist_rd[33:32], hist_rd[15:0]} :
    a_hcur ? {16'h0, hist_rd[31:16]} :
    32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !a_any;

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign trip = trip_q;
  assign drive_enable = !trip_q; // RULE23
  assign stall_lower_freq = stall_q;
  assign stall_decel_start = decel_q;
  assign updown_saved_frequency = updn_q;

endmodule

/* bench/drrp_plant.sv */
// Purpose: Power stage and current sensing that face drrp_top
// Assumes: Bench sets the wanted current and frequency
// Notes: Frequency falls one step a cycle while pull-back is asked
`timescale 1ns/1ps
module drrp_plant (
  input logic pclk,
  input logic presetn,
  input logic stall_lower_freq,
  input logic drive_enable,
  input logic [15:0] set_cur,
  input logic [15:0] set_freq,
  output logic [15:0] motor_current,
  output logic [15:0] out_freq
);
  // ----
  // Response
  // ----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_current <= 16'h0000;
      out_freq <= 16'h0000;
    end else if (!drive_enable) begin
      motor_current <= 16'h0000;
      out_freq <= 16'h0000;
    end else begin
      motor_current <= set_cur;
      out_freq <= stall_lower_freq ? out_freq - 16'h0001 : set_freq;
    end
  end
endmodule

/* bench/drrp_top_sva.sv */
// Purpose: Port checks of drrp_top
// Assumes: Bound to drrp_top
// Notes: One clock domain
`timescale 1ns/1ps
`include "drrp_map.svh"
module drrp_top_sva (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic pslverr,
  input logic out_phase_loss,
  input logic in_phase_loss,
  input logic contactor_switching,
  input logic stop_cmd,
  input logic updown_active,
  input logic updown_clear,
  input logic multi_ramp_select_low,
  input logic multi_ramp_select_mid,
  input logic multi_ramp_select_high,
  input logic drive_enable,
  input logic trip,
  input logic stall_lower_freq,
  input logic stall_decel_start,
  input logic [3:0] ramp_index,
  input logic [15:0] updown_saved_frequency
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire rst_cmd = psel && penable && pwrite && paddr == `DRRP_OFS_CMD && pwdata[0];
  wire [2:0] code = {multi_ramp_select_high, multi_ramp_select_mid, multi_ramp_select_low};
  property p_off; trip |-> !drive_enable; endproperty
  a_off: assert property (p_off) else $error("drive on in trip");
  property p_hold; trip && !rst_cmd |=> trip; endproperty
  a_hold: assert property (p_hold) else $error("trip dropped");
  property p_quiet; !trip && !out_phase_loss && !in_phase_loss && !contactor_switching |=> !trip;
  endproperty
  a_quiet: assert property (p_quiet) else $error("trip without cause");
  property p_multi; code != 3'h0 |=> ramp_index == {1'h0, $past(code)} + 4'h1; endproperty
  a_multi: assert property (p_multi) else $error("bad multi ramp");
  property p_dec; stall_decel_start |-> $past(stop_cmd); endproperty
  a_dec: assert property (p_dec) else $error("decel without stop");
  property p_stl; $past(trip) |-> !stall_lower_freq; endproperty
  a_stl: assert property (p_stl) else $error("pull-back while tripped");
  property p_clr; updown_clear && updown_active |=> updown_saved_frequency == 16'h0000;
  endproperty
  a_clr: assert property (p_clr) else $error("save not cleared");
  property p_keep; updown_active && !updown_clear |=> $stable(updown_saved_frequency);
  endproperty
  a_keep: assert property (p_keep) else $error("saved while held");
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("error outside access");
endmodule
bind drrp_top drrp_top_sva u_sva (.*);

/* bench/drive_ramp_protection_control_test.sv */
// Purpose: Self-checking bench of drrp_top
// Assumes: Zero wait-state APB, short elapsed tick
// Notes: Plant model drives current and frequency
`timescale 1ns/1ps
`include "drrp_map.svh"
module automatic drive_ramp_protection_control_test;
  // ----
  // Signals
  // ----
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, t0;
  logic pready, pslverr, slv, drive_enable, trip, stall_lower_freq, stall_decel_start;
  logic out_phase_loss = 1'h0, in_phase_loss = 1'h0, direct_input_mode = 1'h0;
  logic contactor_switching = 1'h0, accelerating = 1'h0, decelerating = 1'h0;
  logic stop_cmd = 1'h0, updown_active = 1'h0, updown_clear = 1'h0;
  logic multi_ramp_select_low = 1'h0, multi_ramp_select_mid = 1'h0;
  logic multi_ramp_select_high = 1'h0;
  logic [15:0] set_cur = 16'h0, set_freq = 16'h0, target_freq = 16'h0;
  logic [15:0] motor_current, out_freq, span_freq, updown_saved_frequency;
  logic [3:0] ramp_index;
  logic [23:0] accel_ms, decel_ms;
  int n_fail = 0;
  int total_checks = 0;
  always #4 pclk = ~pclk;
  drrp_top #(.TICK_CYCLES(10)) DUT (.*);
  drrp_plant u_plant (.*);
  // ----
  // Tasks
  // ----
  task complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    slv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    cyc(2);
  endtask
  task stl(input logic [15:0] c, input logic [15:0] f, input logic e);
    set_cur <= c;
    set_freq <= f;
    cyc(5);
    chk(stall_lower_freq, e);
  endtask
  task t_regs();
    logic [7:0] a [5] = '{`DRRP_OFS_CTRL, `DRRP_OFS_STALL, `DRRP_OFS_RATED, `DRRP_OFS_FREQ, 8'h3C};
    logic [31:0] e [5] = '{32'h79, 32'h1770_0064, 32'h00C5_00C5, 32'h0, 32'h0};
    for (int i = 0; i < 5; i++) begin
      apb(1'h0, a[i], 32'h0);
      chk(rd, e[i]);
    end
    chk(slv, 1'h1);
    $display("test regs done");
  endtask
  task t_trip();
    set_freq <= 16'h0100;
    in_phase_loss <= 1'h1;
    cyc(3);
    chk(trip, 1'h0);
    in_phase_loss <= 1'h0;
    apb(1'h1, `DRRP_OFS_CTRL, 32'h0000_007F);
    for (int i = 0; i < 3; i++) begin
      set_cur <= 16'(17 * (i + 1));
      cyc(1);
      out_phase_loss <= (i == 0);
      in_phase_loss <= (i == 1);
      contactor_switching <= (i == 2);
      direct_input_mode <= 1'h1;
      accelerating <= (i == 0);
      decelerating <= (i == 1);
      cyc(3);
      chk({trip, drive_enable}, 2'h2);
      apb(1'h0, `DRRP_OFS_STATUS, 32'h0);
      chk(rd[2:0], {2'(i + 1), 1'h1});
      apb(1'h1, `DRRP_OFS_CMD, 32'h1);
      chk(trip, 1'h1);
      {out_phase_loss, in_phase_loss, contactor_switching} <= 3'h0;
      apb(1'h1, `DRRP_OFS_CMD, 32'h1);
      chk(trip, 1'h0);
    end
    for (int j = 0; j < 3; j++) begin
      apb(1'h1, `DRRP_OFS_HSEL, 32'(j));
      apb(1'h0, `DRRP_OFS_HCUR, 32'h0);
      chk(rd[15:0], 16'(51 - 17 * j));
      apb(1'h0, `DRRP_OFS_HFREQ, 32'h0);
      chk({rd[31], rd[17:16], rd[15:0]}, {1'h1, 2'(j * 2 % 3), 16'h0100});
    end
    apb(1'h0, `DRRP_OFS_LASTT, 32'h0);
    t0 = rd;
    apb(1'h1, `DRRP_OFS_CMD, 32'h2);
    apb(1'h0, `DRRP_OFS_HFREQ, 32'h0);
    chk(rd[31], 1'h0);
    apb(1'h0, `DRRP_OFS_LASTT, 32'h0);
    chk(rd > t0, 1'h1);
    accelerating <= 1'h0;
    decelerating <= 1'h0;
    $display("test trip done");
  endtask
  task t_stall();
    apb(1'h1, `DRRP_OFS_RATED, 32'h00C5_0064);
    stl(16'd99, 16'd3000, 1'h0);
    stl(16'd100, 16'd3000, 1'h1);
    stop_cmd <= 1'h1;
    cyc(2);
    chk(stall_decel_start, 1'h1);
    stop_cmd <= 1'h0;
    apb(1'h1, `DRRP_OFS_CTRL, 32'h6F);
    chk(stall_lower_freq, 1'h0);
    accelerating <= 1'h1;
    stl(16'd100, 16'd3000, 1'h1);
    accelerating <= 1'h0;
    apb(1'h1, `DRRP_OFS_CTRL, 32'h0000_007F);
    stl(16'd75, 16'd7000, 1'h1);
    stl(16'd74, 16'd7000, 1'h0);
    stl(16'd75, 16'd3000, 1'h0);
    apb(1'h1, `DRRP_OFS_RATED, 32'h0032_0064);
    apb(1'h1, `DRRP_OFS_STALL, 32'h1770_00C8);
    stl(16'd60, 16'd3000, 1'h1);
    stl(16'd59, 16'd3000, 1'h0);
    set_cur <= 16'h0;
    $display("test stall done");
  endtask
  task t_ramp();
    int stp [3] = '{`DRRP_STEP_FINE_MS, `DRRP_STEP_MID_MS, `DRRP_STEP_COARSE_MS};
    set_freq <= 16'd2000;
    target_freq <= 16'd5000;
    apb(1'h1, `DRRP_OFS_RAMP1, 32'h00C8_0032);
    apb(1'h1, `DRRP_OFS_RAMP2, 32'h1B58_001E);
    apb(1'h1, `DRRP_OFS_FREQ, 32'd1000);
    for (int s = 0; s < 3; s++) begin
      apb(1'h1, `DRRP_OFS_CTRL, 32'h3F | (s << 6));
      chk(ramp_index, 4'h1);
      chk(accel_ms, 30 * stp[s]);
      chk(decel_ms, 6000 * stp[s]);
    end
    chk(span_freq, 16'd6000);
    apb(1'h1, `DRRP_OFS_FREQ, 32'd3000);
    chk({ramp_index, accel_ms}, {4'h0, 24'd50000});
    for (int c = 1; c < 8; c++) begin
      {multi_ramp_select_high, multi_ramp_select_mid, multi_ramp_select_low} <= 3'(c);
      cyc(3);
      chk(ramp_index, c + 1);
    end
    {multi_ramp_select_high, multi_ramp_select_mid, multi_ramp_select_low} <= 3'h0;
    apb(1'h1, `DRRP_OFS_CTRL, 32'h17F);
    chk(span_freq, 16'd3000);
    $display("test ramp done");
  endtask
  task t_updown();
    set_freq <= 16'd1234;
    apb(1'h1, `DRRP_OFS_CTRL, 32'h27F);
    updown_active <= 1'h1;
    cyc(3);
    updown_active <= 1'h0;
    apb(1'h0, `DRRP_OFS_UPDN, 32'h0);
    chk(rd, 32'd1234);
    updown_active <= 1'h1;
    updown_clear <= 1'h1;
    cyc(3);
    updown_clear <= 1'h0;
    chk(updown_saved_frequency, 16'h0000);
    apb(1'h1, `DRRP_OFS_CTRL, 32'h0000_007F);
    updown_active <= 1'h0;
    cyc(3);
    chk(updown_saved_frequency, 16'h0000);
    $display("test updown done");
  endtask
  // ----
  // Run
  // ----
  initial begin
    cyc(4);
    presetn <= 1'h1;
    t_regs();
    t_trip();
    t_stall();
    t_ramp();
    t_updown();
    complete_run();
  end
  initial begin
    cyc(20000);
    n_fail++;
    complete_run();
  end
endmodule
